// file: core/test_bias_cfg_defines.vh
// Offsets, field positions, reset values and timing counts of the test and bias configuration.
`ifndef TEST_BIAS_CFG_DEFINES_VH
`define TEST_BIAS_CFG_DEFINES_VH

// Register indices and byte addresses.
`define TEST_SIGNAL_CONFIG_IDX 8'h02
`define REF_BIAS_CONFIG_IDX 8'h03
`define TEST_SIGNAL_CONFIG_ADDR 10'h008
`define REF_BIAS_CONFIG_ADDR 10'h00c
`define WB_ADDR_W 10

// Test signal configuration fields.
`define TSC_ONE_BIT 5
`define TSC_INT_SRC_BIT 4
`define TSC_AMP_BIT 2
`define TSC_RATE_LSB 0
`define TSC_RESET 8'h00
`define TSC_WRITE_MASK 8'h37

// Reference and bias configuration fields.
`define RBC_REFBUF_BIT 7
`define RBC_ONE_BIT 6
`define RBC_REFHI_BIT 5
`define RBC_MEAS_BIT 4
`define RBC_REFINT_BIT 3
`define RBC_BIASBUF_BIT 2
`define RBC_SENSE_BIT 1
`define RBC_STAT_BIT 0
`define RBC_RESET 8'h40
`define RBC_WRITE_MASK 8'hbe

// Calibration rate codes.
`define CAL_RATE_SLOW 2'h0
`define CAL_RATE_FAST 2'h1
`define CAL_RATE_UNUSED 2'h2
`define CAL_RATE_DC 2'h3

// Pulse generator divisor exponents; the output toggles at half the full period.
`define CAL_SLOW_EXP 21
`define CAL_FAST_EXP 20
`define CAL_CNT_W 21

// Channel input selector code that picks up the bias-drive measurement.
`define SEL_BIAS_MEAS 3'h2

`endif

// file: core/cal_pulse_gen.v
// Calibration square-wave generator built on a free-running divider.
`timescale 1ns/1ns
`default_nettype none
`include "test_bias_cfg_defines.vh"

module cal_pulse_gen
(
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	input wire enable_i,
	input wire [1:0] rate_sel_i,
	output wire pulse_o
);

	reg [`CAL_CNT_W-1:0] div_ff;
	reg [`CAL_CNT_W-1:0] nxt_div;
	reg pulse_ff;
	reg nxt_pulse;

	// ----------------------------------------
	// Divider
	// ----------------------------------------
	// The counter runs freely; the selected bit is the square wave, so the full
	// period is exactly two to the chosen exponent clock cycles with ce_i high.
	always @*
	begin
		nxt_div = div_ff + {{(`CAL_CNT_W-1){1'b0}}, 1'b1};
		nxt_pulse = 1'b0;
		if (enable_i)
		begin
			case (rate_sel_i)
				`CAL_RATE_SLOW:
				begin
					nxt_pulse = nxt_div[`CAL_SLOW_EXP-1];
				end
				`CAL_RATE_FAST, `CAL_RATE_UNUSED:
				begin
					nxt_pulse = nxt_div[`CAL_FAST_EXP-1];
				end
				`CAL_RATE_DC:
				begin
					nxt_pulse = 1'b1;
				end
				default:
				begin
					nxt_pulse = 1'b0;
				end
			endcase
		end
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			div_ff <= {`CAL_CNT_W{1'b0}};
			pulse_ff <= 1'b0;
		end
		else if (ce_i)
		begin
			div_ff <= nxt_div;
			pulse_ff <= nxt_pulse;
		end
	end

	assign pulse_o = pulse_ff;

endmodule
`default_nettype wire

// file: core/test_signal_bias_ref_config.v
// Test-signal and reference/bias configuration registers on a classic Wishbone slave.
`timescale 1ns/1ns
`default_nettype none
`include "test_bias_cfg_defines.vh"

// Notes on behaviour
// - Test bit 5 resets zero; software writes one.
// - Test source bit: zero external, one internal.
// - Amplitude bit: zero single, one double level.
// - Rate code 00 slow, 01 fast, 11 dc.
// - Bias register bit 6 resets one, stays one.
// - Reference buffer powered only when bit set.
// - Reference level high selects 4V; 5V supply.
// - Bias measure routes drive to selector 010.
// - Bias reference internal midpoint when bit set.
// - Bias buffer powered only when bit set.
// - Bias sense enabled only when bit set.
// - Status reads one when electrode disconnected.
// - Selector 010 plus measure bit measures drive.
module test_signal_bias_ref_config
(
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [`WB_ADDR_W-1:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output wire [31:0] wb_dat_o,
	output wire wb_ack_o,
	output wire wb_err_o,
	input wire bias_lead_open_i,
	input wire [23:0] channel_input_selector_i,
	output wire test_source_internal_o,
	output wire cal_amplitude_sel_o,
	output wire [1:0] cal_rate_sel_o,
	output wire cal_pulse_o,
	output wire ref_buffer_enable_o,
	output wire ref_level_high_o,
	output wire bias_drive_measure_o,
	output wire [7:0] bias_measure_route_o,
	output wire bias_ref_internal_o,
	output wire bias_buffer_enable_o,
	output wire bias_sense_enable_o,
	output wire bias_disconnect_flag_o
);

	reg [7:0] tsc_ff;
	reg [7:0] rbc_ff;
	reg stat_ff;
	reg ack_ff;
	reg err_ff;
	reg [31:0] dat_ff;
	reg [7:0] route_ff;
	reg [7:0] nxt_route;
	reg [31:0] nxt_dat;
	wire req;
	wire hit_tsc;
	wire hit_rbc;
	wire wr_lane0;
	integer i;

	// Merges a masked write into a stored byte, keeping bits outside the mask.
	function [7:0] merge_byte;
		input [7:0] old_val;
		input [7:0] new_val;
		input [7:0] mask;
		begin
			merge_byte = (old_val & ~mask) | (new_val & mask);
		end
	endfunction

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	// A request is taken once: the ack or error pulse blocks it in the following cycle.
	assign req = wb_cyc_i & wb_stb_i & ~ack_ff & ~err_ff;
	assign hit_tsc = (wb_adr_i == `TEST_SIGNAL_CONFIG_ADDR);
	assign hit_rbc = (wb_adr_i == `REF_BIAS_CONFIG_ADDR);
	assign wr_lane0 = req & wb_we_i & wb_sel_i[0];

	always @*
	begin
		nxt_dat = 32'h00000000;
		if (hit_tsc)
		begin
			nxt_dat[7:0] = tsc_ff;
		end
		else if (hit_rbc)
		begin
			nxt_dat[7:0] = {rbc_ff[7:1], stat_ff};
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Bits 7, 6 and 3 of the test register are held at zero whatever software
	// writes; bit 5 powers up zero and then follows the write.
	// Bit 6 of the bias register is forced to one, and the status bit ignores
	// writes and follows the sense circuit.
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tsc_ff <= `TSC_RESET;
			rbc_ff <= `RBC_RESET;
			stat_ff <= 1'b0;
			ack_ff <= 1'b0;
			err_ff <= 1'b0;
			dat_ff <= 32'h00000000;
		end
		else if (ce_i)
		begin
			ack_ff <= req & (hit_tsc | hit_rbc);
			err_ff <= req & ~(hit_tsc | hit_rbc);
			stat_ff <= bias_lead_open_i;
			if (req & ~wb_we_i)
			begin
				dat_ff <= nxt_dat;
			end
			if (wr_lane0 & hit_tsc)
			begin
				tsc_ff <= merge_byte(tsc_ff, wb_dat_i[7:0], `TSC_WRITE_MASK);
			end
			if (wr_lane0 & hit_rbc)
			begin
				rbc_ff <= merge_byte(rbc_ff, wb_dat_i[7:0], `RBC_WRITE_MASK)
					| (8'h01 << `RBC_ONE_BIT);
			end
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_err_o = err_ff;
	assign wb_dat_o = dat_ff;

	// ----------------------------------------
	// Bias measurement routing
	// ----------------------------------------
	// One route bit per channel, set while measurement is on and that
	// channel's three-bit selector holds the measurement code.
	always @*
	begin
		nxt_route = 8'h00;
		for (i = 0; i < 8; i = i + 1)
		begin
			nxt_route[i] = rbc_ff[`RBC_MEAS_BIT] &
				(channel_input_selector_i[i*3 +: 3] == `SEL_BIAS_MEAS);
		end
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			route_ff <= 8'h00;
		end
		else if (ce_i)
		begin
			route_ff <= nxt_route;
		end
	end

	assign bias_measure_route_o = route_ff;

	// ----------------------------------------
	// Analog controls
	// ----------------------------------------
	assign test_source_internal_o = tsc_ff[`TSC_INT_SRC_BIT];
	assign cal_amplitude_sel_o = tsc_ff[`TSC_AMP_BIT];
	assign cal_rate_sel_o = tsc_ff[`TSC_RATE_LSB +: 2];
	assign ref_buffer_enable_o = rbc_ff[`RBC_REFBUF_BIT];
	assign ref_level_high_o = rbc_ff[`RBC_REFHI_BIT];
	assign bias_drive_measure_o = rbc_ff[`RBC_MEAS_BIT];
	assign bias_ref_internal_o = rbc_ff[`RBC_REFINT_BIT];
	assign bias_buffer_enable_o = rbc_ff[`RBC_BIASBUF_BIT];
	assign bias_sense_enable_o = rbc_ff[`RBC_SENSE_BIT];
	assign bias_disconnect_flag_o = stat_ff;

	// ----------------------------------------
	// Calibration pulse
	// ----------------------------------------
	// The generator drives its output only when the test signal is sourced internally; its divider counts on every ce_i cycle whatever the source.
	cal_pulse_gen u_cal_pulse_gen
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.enable_i(tsc_ff[`TSC_INT_SRC_BIT]),
		.rate_sel_i(tsc_ff[`TSC_RATE_LSB +: 2]),
		.pulse_o(cal_pulse_o)
	);

endmodule
`default_nettype wire

// file: verification/test_signal_bias_ref_config_properties.sv
// Bus and output properties of the test and bias configuration block.
`timescale 1ns/1ns
`default_nettype none
`include "test_bias_cfg_defines.vh"
module test_signal_bias_ref_config_properties
(
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [`WB_ADDR_W-1:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	input wire wb_err_o,
	input wire bias_lead_open_i,
	input wire [23:0] channel_input_selector_i,
	input wire test_source_internal_o,
	input wire [1:0] cal_rate_sel_o,
	input wire cal_pulse_o,
	input wire ref_buffer_enable_o,
	input wire bias_drive_measure_o,
	input wire [7:0] bias_measure_route_o,
	input wire bias_disconnect_flag_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire req = wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o && !wb_err_o;
	wire tsc = wb_adr_i == `TEST_SIGNAL_CONFIG_ADDR;
	wire rbc = wb_adr_i == `REF_BIAS_CONFIG_ADDR;
	property p_ack;
		req && (tsc || rbc) |=> wb_ack_o && !wb_err_o;
	endproperty
	a_ack: assert property (p_ack) else $error("mapped access not acked");
	property p_err;
		req && !tsc && !rbc |=> wb_err_o && !wb_ack_o;
	endproperty
	a_err: assert property (p_err) else $error("unmapped access not refused");
	property p_zero;
		req && !wb_we_i && tsc |=> wb_dat_o[7:6] == 2'h0 && !wb_dat_o[3];
	endproperty
	a_zero: assert property (p_zero) else $error("fixed zero bits read set");
	property p_one;
		req && !wb_we_i && rbc |=> wb_dat_o[6];
	endproperty
	a_one: assert property (p_one) else $error("fixed one bit read clear");
	property p_wr;
		req && wb_we_i && wb_sel_i[0] && rbc |=> ref_buffer_enable_o == $past(wb_dat_i[7]);
	endproperty
	a_wr: assert property (p_wr) else $error("buffer enable not written");
	property p_flag;
		ce_i |=> bias_disconnect_flag_o == $past(bias_lead_open_i);
	endproperty
	a_flag: assert property (p_flag) else $error("status does not track sensor");
	property p_route;
		ce_i |=> bias_measure_route_o[3] ==
			$past(bias_drive_measure_o && channel_input_selector_i[11:9] == `SEL_BIAS_MEAS);
	endproperty
	a_route: assert property (p_route) else $error("measure route wrong");
	property p_ext;
		ce_i && !test_source_internal_o |=> !cal_pulse_o;
	endproperty
	a_ext: assert property (p_ext) else $error("pulse with external source");
	property p_dc;
		ce_i && test_source_internal_o && cal_rate_sel_o == `CAL_RATE_DC |=> cal_pulse_o;
	endproperty
	a_dc: assert property (p_dc) else $error("dc level missing");
endmodule
bind test_signal_bias_ref_config test_signal_bias_ref_config_properties u_chk (.*);
`default_nettype wire

// file: verification/test_signal_bias_ref_config_tb_top.sv
// Self-checking bench for the test and bias configuration registers.
`timescale 1ns/1ns
`default_nettype none
`include "test_bias_cfg_defines.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; \
	$display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module test_signal_bias_ref_config_tb_top;
	logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, e;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, bias_lead_open_i = 1'b0;
	logic [9:0] wb_adr_i = 10'h000;
	logic [3:0] wb_sel_i = 4'h1;
	logic [31:0] wb_dat_i = 32'h0, q;
	logic [23:0] channel_input_selector_i = 24'h0;
	wire [31:0] wb_dat_o;
	wire [1:0] cal_rate_sel_o;
	wire [7:0] bias_measure_route_o;
	wire wb_ack_o, wb_err_o, test_source_internal_o, cal_amplitude_sel_o, cal_pulse_o;
	wire ref_buffer_enable_o, ref_level_high_o, bias_drive_measure_o, bias_ref_internal_o;
	wire bias_buffer_enable_o, bias_sense_enable_o, bias_disconnect_flag_o;
	wire [5:0] rb = {ref_buffer_enable_o, ref_level_high_o, bias_drive_measure_o,
		bias_ref_internal_o, bias_buffer_enable_o, bias_sense_enable_o};
	int miscompares = 0, total_checks = 0;
	localparam T = `TEST_SIGNAL_CONFIG_ADDR;
	localparam B = `REF_BIAS_CONFIG_ADDR;
	always #25 clk_i = ~clk_i;
	test_signal_bias_ref_config dut (.*);
	task results;
		if (miscompares == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task xfer(input logic [9:0] a, input logic w, input logic [7:0] d, input logic [3:0] s);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= {24'h0, d};
		wb_sel_i <= s;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1)
		begin
			miscompares++;
			results;
		end
		else
		begin
			q = wb_dat_o;
			e = wb_err_o;
			wb_cyc_i <= 1'b0;
			wb_stb_i <= 1'b0;
		end
	endtask
	task wr(input logic [9:0] a, input logic [7:0] d);
		xfer(a, 1'b1, d, 4'h1);
	endtask
	task rd(input logic [9:0] a, input logic [7:0] x);
		xfer(a, 1'b0, 8'h00, 4'h1);
		`CHK(q, {24'h0, x})
	endtask
	initial
	begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(T, 8'h00);
		rd(B, 8'h40);
		`CHK({test_source_internal_o, cal_amplitude_sel_o, cal_rate_sel_o}, 4'h0)
		wr(T, 8'h37);
		rd(T, 8'h37);
		for (int c = 0; c < 4; c += (c == 1) ? 2 : 1)
		begin
			wr(T, {6'h0d, c[1:0]});
			`CHK({test_source_internal_o, cal_amplitude_sel_o, cal_rate_sel_o}, {2'h3, c[1:0]})
		end
		repeat (2) @(negedge clk_i);
		`CHK(cal_pulse_o, 1'b1)
		wr(T, 8'h23);
		repeat (2) @(negedge clk_i);
		`CHK(cal_pulse_o, 1'b0)
		for (int i = 1; i < 8; i++)
		begin
			wr(B, 8'h40 | (8'h01 << i));
			rd(B, 8'h40 | (8'h01 << i));
			`CHK(rb, {i == 7, i == 5, i == 4, i == 3, i == 2, i == 1})
		end
		xfer(B, 1'b1, 8'h7e, 4'h0);
		rd(B, 8'hc0);
		bias_lead_open_i <= 1'b1;
		wr(B, 8'h40);
		rd(B, 8'h41);
		`CHK(bias_disconnect_flag_o, 1'b1)
		channel_input_selector_i <= 24'h000428;
		wr(B, 8'h50);
		repeat (2) @(negedge clk_i);
		`CHK(bias_measure_route_o, 8'h08)
		wr(B, 8'h40);
		repeat (2) @(negedge clk_i);
		`CHK(bias_measure_route_o, 8'h00)
		@(posedge clk_i);
		ce_i <= 1'b0;
		bias_lead_open_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		`CHK(bias_disconnect_flag_o, 1'b1)
		ce_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		`CHK(bias_disconnect_flag_o, 1'b0)
		xfer(10'h010, 1'b0, 8'h00, 4'h1);
		`CHK({e, q}, 33'h100000000)
		results;
	end
endmodule
`default_nettype wire
